//--- src/cpr_pkg.sv
// cpr_pkg: register map, field layout, reset values and threshold scaling
// for the charger protection threshold bank.
// assumes: only the bank module and its bench use these names.
package cpr_pkg;
  // register offsets on the internal register port
  localparam logic [7:0] ADDR_UCP_ALARM = 8'h04;
  localparam logic [7:0] ADDR_ADAPTER   = 8'h05;
  localparam logic [7:0] ADDR_BUS_OVERVOLTAGE_THRESHOLD   = 8'h06;

  // reset values
  localparam logic [7:0] RST_UCP_ALARM = 8'h28;
  localparam logic [7:0] RST_ADAPTER   = 8'h03;
  localparam logic [7:0] RST_BUS_OVERVOLTAGE_THRESHOLD   = 8'h3A;

  // field positions
  localparam int UCP_DIS_BIT    = 7;
  localparam int ADP_STAT_BIT   = 6 + 1;
  localparam int ADP_FLAG_BIT   = 6;
  localparam int ADP_MASK_BIT   = 5;
  localparam int BUS_PD_EN_BIT  = 7;
  localparam int CODE7_MSB      = 6;
  localparam int ADP_CODE_MSB   = 2;

  // writable bits of the adapter register (mask and threshold code)
  localparam logic [7:0] ADP_WR_MASK = 8'h27;

  // threshold scaling, in mA and mV
  localparam logic [13:0] UCP_STEP_MA    = 14'h0032;
  localparam logic [14:0] ADP_BASE_MV    = 15'h2AF8;
  localparam logic [14:0] ADP_STEP_MV    = 15'h03E8;
  localparam logic [14:0] ADP_ALT_MV     = 15'h1964;
  localparam logic [2:0]  ADP_ALT_CODE   = 3'h7;
  localparam logic [13:0] BUS_BASE_MV    = 14'h1770;
  localparam logic [13:0] BUS_STEP_MV    = 14'h0032;
endpackage

//--- src/cpr_sync.sv
// cpr_sync: three-flop synchroniser with an agreement filter for one
// asynchronous comparator level.
// assumes: the input is a slow level from analog, not a pulse.
`timescale 1ns/1ps
module cpr_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and filtered level out
  input  wire logic din,
  output logic      q
);
  logic s1, s2, s3;
  logic next_q;

  // a change is taken only once the second and third flops agree
  always_comb begin
    next_q = (s2 == s3) ? s3 : q;
  end

  // s1 feeds s2 only; metastability never reaches the filter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q  <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule

//--- src/cpr_bank.sv
// cpr_bank: three protection threshold registers with the flag, mask and
// control outputs that they steer.
// assumes: the serial port logic drives the register port in REF_CLK,
// the comparator levels are asynchronous, the charge-enable bit lives
// elsewhere and obeys a clear pulse.
// Notes on behaviour
// RULE_01: undercurrent alarm interrupts unless disabled
// RULE_02: undercurrent threshold is code times 50 mA
// RULE_03: register reset restores fields; watchdog does not
// RULE_04: host watches battery current for handover
// RULE_05: adapter overvoltage status bit is live
// RULE_06: adapter overvoltage flag latches, clears on read
// RULE_07: mask bit blocks adapter overvoltage interrupt
// RULE_08: adapter overvoltage switches external FET off
// RULE_09: adapter threshold 11 V plus 1 V steps
// RULE_10: host keeps bus under adapter threshold
// RULE_11: pulldown enable turns FET off, pulldown on
// RULE_12: stopped charge pump forces pulldown on
// RULE_13: bus overvoltage opens switch, clears charge enable
// RULE_14: bus threshold 50 mV steps, default 8.9 V
// RULE_15: interrupt follows unmasked flags until read
`timescale 1ns/1ps
module cpr_bank (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // register port from the serial interface
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        REG_RESET,
  // comparator and pump levels, asynchronous
  input  wire logic        BAT_UNDERCURRENT,
  input  wire logic        ADAPTER_OVERVOLTAGE,
  input  wire logic        BUS_OVERVOLTAGE,
  input  wire logic        CHARGE_PUMP_RUNNING,
  // thresholds to the comparators
  output logic      [13:0] UCP_THRESHOLD_MA,
  output logic      [14:0] ADAPTER_THRESHOLD_MV,
  output logic      [13:0] BUS_THRESHOLD_MV,
  // power path controls and interrupt
  output logic             EXTERNAL_FET_GATE_DRIVE,
  output logic             BUS_PULLDOWN_ON,
  output logic             BLOCKING_SWITCH_ON,
  output logic             CHARGE_ENABLE_CLEAR,
  output logic             IRQ
);
  logic       uc, ac, bo, cp;
  logic       ac_d, bo_d;
  logic [7:0] ucp_reg, adp_reg, bus_reg;
  logic       flag;
  logic [7:0] next_ucp, next_adp, next_bus, next_rdata;
  logic       next_flag, next_irq, next_fet, next_pd, next_sw, next_clr;
  logic [13:0] next_ucp_ma, next_bus_mv;
  logic [14:0] next_adp_mv;
  logic        ac_rise, flag_read;

  // comparator levels cross into REF_CLK
  cpr_sync #(.INIT(1'b0)) u_sync_uc (.clk(REF_CLK), .rst(RST), .din(BAT_UNDERCURRENT),
                                     .q(uc));
  cpr_sync #(.INIT(1'b0)) u_sync_ac (.clk(REF_CLK), .rst(RST), .din(ADAPTER_OVERVOLTAGE),
                                     .q(ac));
  cpr_sync #(.INIT(1'b0)) u_sync_bo (.clk(REF_CLK), .rst(RST), .din(BUS_OVERVOLTAGE),
                                     .q(bo));
  cpr_sync #(.INIT(1'b0)) u_sync_cp (.clk(REF_CLK), .rst(RST), .din(CHARGE_PUMP_RUNNING),
                                     .q(cp));

  assign ac_rise   = ac && !ac_d;
  assign flag_read = REG_RD && (REG_ADDR == cpr_pkg::ADDR_ADAPTER);

  // register writes; the reset command wins over a write in the same cycle
  always_comb begin
    next_ucp = ucp_reg;
    next_adp = adp_reg;
    next_bus = bus_reg;
    if (REG_RESET) begin
      next_ucp = cpr_pkg::RST_UCP_ALARM; // RULE_03
      next_adp = cpr_pkg::RST_ADAPTER; // RULE_03
      next_bus = cpr_pkg::RST_BUS_OVERVOLTAGE_THRESHOLD; // RULE_03
    end else if (REG_WR) begin
      if (REG_ADDR == cpr_pkg::ADDR_UCP_ALARM) begin
        next_ucp = REG_WDATA;
      end else if (REG_ADDR == cpr_pkg::ADDR_ADAPTER) begin
        next_adp = REG_WDATA & cpr_pkg::ADP_WR_MASK;
      end else if (REG_ADDR == cpr_pkg::ADDR_BUS_OVERVOLTAGE_THRESHOLD) begin
        next_bus = REG_WDATA;
      end
    end
  end

  // flag: an event in the cycle of a read survives the clear
  always_comb begin
    next_flag = flag;
    if (REG_RESET) begin
      next_flag = 1'b0; // RULE_03
    end else if (ac_rise) begin
      next_flag = 1'b1; // RULE_06
    end else if (flag_read) begin
      next_flag = 1'b0; // RULE_06
    end
  end

  // read data holds until the next read; unmapped offsets read zero
  always_comb begin
    next_rdata = REG_RDATA;
    if (REG_RD) begin
      if (REG_ADDR == cpr_pkg::ADDR_UCP_ALARM) begin
        next_rdata = ucp_reg;
      end else if (REG_ADDR == cpr_pkg::ADDR_ADAPTER) begin
        next_rdata = adp_reg;
        next_rdata[cpr_pkg::ADP_STAT_BIT] = ac; // RULE_05
        next_rdata[cpr_pkg::ADP_FLAG_BIT] = flag;
      end else if (REG_ADDR == cpr_pkg::ADDR_BUS_OVERVOLTAGE_THRESHOLD) begin
        next_rdata = bus_reg;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // threshold decode; the all-ones adapter code is a low special setting
  always_comb begin
    next_ucp_ma = 14'(ucp_reg[cpr_pkg::CODE7_MSB:0] * cpr_pkg::UCP_STEP_MA); // RULE_02
    next_bus_mv = 14'(cpr_pkg::BUS_BASE_MV
                  + bus_reg[cpr_pkg::CODE7_MSB:0] * cpr_pkg::BUS_STEP_MV); // RULE_14
    if (adp_reg[cpr_pkg::ADP_CODE_MSB:0] == cpr_pkg::ADP_ALT_CODE) begin
      next_adp_mv = cpr_pkg::ADP_ALT_MV; // RULE_09
    end else begin
      next_adp_mv = 15'(cpr_pkg::ADP_BASE_MV
                    + adp_reg[cpr_pkg::ADP_CODE_MSB:0] * cpr_pkg::ADP_STEP_MV); // RULE_09
    end
  end

  // power path: any reason to open the FET wins over the pump
  always_comb begin
    next_fet = cp && !ac && !bus_reg[cpr_pkg::BUS_PD_EN_BIT]; // RULE_08 RULE_11
    next_pd  = !cp || bus_reg[cpr_pkg::BUS_PD_EN_BIT]; // RULE_11 RULE_12
    next_sw  = !bo; // RULE_13
    next_clr = bo && !bo_d; // RULE_13
    // undercurrent alarm is a level; no flag bit exists for it here
    next_irq = (uc && !ucp_reg[cpr_pkg::UCP_DIS_BIT]) // RULE_01
             || (next_flag && !adp_reg[cpr_pkg::ADP_MASK_BIT]); // RULE_07 RULE_15
  end

  // state and output registers; no watchdog input touches them
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ucp_reg                 <= cpr_pkg::RST_UCP_ALARM;
      adp_reg                 <= cpr_pkg::RST_ADAPTER;
      bus_reg                 <= cpr_pkg::RST_BUS_OVERVOLTAGE_THRESHOLD;
      flag                    <= 1'b0;
      ac_d                    <= 1'b0;
      bo_d                    <= 1'b0;
      REG_RDATA               <= 8'h00;
      UCP_THRESHOLD_MA        <= 14'h07D0;
      ADAPTER_THRESHOLD_MV    <= 15'h36B0;
      BUS_THRESHOLD_MV        <= 14'h22C4;
      EXTERNAL_FET_GATE_DRIVE <= 1'b0;
      BUS_PULLDOWN_ON         <= 1'b1;
      BLOCKING_SWITCH_ON      <= 1'b1;
      CHARGE_ENABLE_CLEAR     <= 1'b0;
      IRQ                     <= 1'b0;
    end else begin
      ucp_reg                 <= next_ucp;
      adp_reg                 <= next_adp;
      bus_reg                 <= next_bus;
      flag                    <= next_flag;
      ac_d                    <= ac;
      bo_d                    <= bo;
      REG_RDATA               <= next_rdata;
      UCP_THRESHOLD_MA        <= next_ucp_ma;
      ADAPTER_THRESHOLD_MV    <= next_adp_mv;
      BUS_THRESHOLD_MV        <= next_bus_mv;
      EXTERNAL_FET_GATE_DRIVE <= next_fet;
      BUS_PULLDOWN_ON         <= next_pd;
      BLOCKING_SWITCH_ON      <= next_sw;
      CHARGE_ENABLE_CLEAR     <= next_clr;
      IRQ                     <= next_irq;
    end
  end

  // checks beside the logic they guard
  chk_ucp_alarm_irq: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_01
    (uc && !ucp_reg[cpr_pkg::UCP_DIS_BIT]) |=> IRQ)
    else $error("undercurrent alarm did not raise the interrupt");

  chk_ucp_thresh_scale: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_02
    ##1 (UCP_THRESHOLD_MA == 14'($past(ucp_reg[6:0]) * 50)))
    else $error("undercurrent threshold not code times 50 mA");

  chk_regrst_restores: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_03
    REG_RESET |=> (ucp_reg == 8'h28 && adp_reg == 8'h03 && bus_reg == 8'h3A && !flag))
    else $error("register reset did not restore the bank");

  chk_status_live: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_05
    (REG_RD && REG_ADDR == 8'h05) |=> (REG_RDATA[7] == $past(ac)))
    else $error("adapter status bit not the live condition");

  chk_flag_event_set: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_06
    (ac_rise && !REG_RESET) |=> flag)
    else $error("adapter flag not set by overvoltage event");

  chk_flag_read_clear: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_06
    (flag_read && !ac_rise) |=> !flag)
    else $error("adapter flag not cleared by read");

  chk_mask_blocks_irq: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_07
    (adp_reg[5] && !(uc && !ucp_reg[7])) |=> !IRQ)
    else $error("masked adapter event reached the interrupt");

  chk_fet_off_ovp: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_08
    ac |=> !EXTERNAL_FET_GATE_DRIVE)
    else $error("external FET not switched off on adapter overvoltage");

  chk_adp_alt_code: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_09
    (adp_reg[2:0] == 3'h7) |=> (ADAPTER_THRESHOLD_MV == 15'd6500))
    else $error("all-ones adapter code did not give 6.5 V");

  chk_pulldown_force: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_12
    (!cp || bus_reg[7]) |=> (BUS_PULLDOWN_ON && !EXTERNAL_FET_GATE_DRIVE))
    else $error("pulldown not active with pump stopped or enabled");

  chk_bus_overvoltage_threshold_trip: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_13
    (bo && !bo_d) |=> (!BLOCKING_SWITCH_ON && CHARGE_ENABLE_CLEAR) ##1 !CHARGE_ENABLE_CLEAR)
    else $error("bus overvoltage did not open switch and pulse clear");

  chk_bus_thresh_scale: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_14
    ##1 (BUS_THRESHOLD_MV == 14'(6000 + $past(bus_reg[6:0]) * 50)))
    else $error("bus threshold not 6 V plus code times 50 mV");

  chk_irq_follows_flags: assert property (@(posedge REF_CLK) disable iff (RST) // RULE_15
    (!uc && !next_flag) |=> !IRQ)
    else $error("interrupt stayed high with no unmasked cause");
endmodule

//--- testbench/cpr_host.sv
// cpr_host: host model that drives the strobe register port.
// assumes: strobes change on falling clk, one byte per access.
`timescale 1ns/1ps
module cpr_host (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] addr,
  output logic            wr,
  output logic      [7:0] wdata,
  output logic            rd,
  output logic            reg_reset,
  input  wire logic [7:0] rdata
);
  // idle values; address parked off the map so a stray strobe decodes nothing
  initial begin
    addr = 8'hFF;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
    reg_reset = 1'b0;
  end
  // one-cycle write strobe with address and data held across it
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // read data is sampled once, at the falling edge after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  // register reset command, one cycle
  task automatic pulse_reset();
    @(negedge clk);
    reg_reset = 1'b1;
    @(negedge clk);
    reg_reset = 1'b0;
  endtask
endmodule

//--- testbench/cpr_bank_bench.sv
// cpr_bank_bench: self-checking bench for the protection threshold bank.
// assumes: cpr_host drives the register port; comparator levels are set here.
`timescale 1ns/1ps
module cpr_bank_bench;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } cpr_row_t;
  // clock, reset and comparator levels
  logic        clk;
  logic        rst;
  logic        uc;
  logic        aovp;
  logic        bovp;
  logic        pump;
  // register port
  logic [7:0]  addr;
  logic        wr;
  logic [7:0]  wdata;
  logic        rd;
  logic        reg_reset;
  logic [7:0]  rdata;
  // design outputs
  logic [13:0] ucp_ma;
  logic [14:0] adp_mv;
  logic [13:0] bus_mv;
  logic        fet;
  logic        pd;
  logic        sw;
  logic        ce_clr;
  logic        irq;
  int          err_count;
  int          num_checks;
  int          pulses;
  logic [7:0]  rv;
  cpr_row_t    rows [4];

  cpr_bank dut_u (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RESET(reg_reset),
    .BAT_UNDERCURRENT(uc), .ADAPTER_OVERVOLTAGE(aovp), .BUS_OVERVOLTAGE(bovp),
    .CHARGE_PUMP_RUNNING(pump), .UCP_THRESHOLD_MA(ucp_ma), .ADAPTER_THRESHOLD_MV(adp_mv),
    .BUS_THRESHOLD_MV(bus_mv), .EXTERNAL_FET_GATE_DRIVE(fet), .BUS_PULLDOWN_ON(pd),
    .BLOCKING_SWITCH_ON(sw), .CHARGE_ENABLE_CLEAR(ce_clr), .IRQ(irq));
  cpr_host host_u (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd),
    .reg_reset(reg_reset), .rdata(rdata));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.read_reg(a, rv);
    chk("read", {8'h00, exp}, {8'h00, rv});
  endtask
  // levels need five edges through the filter and output register; eight leaves margin
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 145 cycles the run needs
  initial begin
    #20000;
    err_count++;
    conclude();
  end
  // main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    rows = '{'{8'h04, 8'hFF, 8'hFF}, '{8'h05, 8'hFF, 8'h27},
             '{8'h06, 8'h80, 8'h80}, '{8'h09, 8'h55, 8'h00}};
    {uc, aovp, bovp, pump} = 4'h0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rchk(cpr_pkg::ADDR_UCP_ALARM, cpr_pkg::RST_UCP_ALARM);
    rchk(cpr_pkg::ADDR_ADAPTER, cpr_pkg::RST_ADAPTER);
    rchk(cpr_pkg::ADDR_BUS_OVERVOLTAGE_THRESHOLD, cpr_pkg::RST_BUS_OVERVOLTAGE_THRESHOLD);
    chk("ucp", 16'h07D0, {2'b00, ucp_ma});
    chk("adp", 16'h36B0, {1'b0, adp_mv});
    chk("bus", 16'h22C4, {2'b00, bus_mv});
    chk("pd", 16'h0001, {15'h0000, pd});
    // table rows: write then read back, read-only and unmapped bits stay clear
    foreach (rows[i]) begin
      host_u.write_reg(rows[i].addr, rows[i].wdata);
      rchk(rows[i].addr, rows[i].rexp);
    end
    chk("ucp", 16'h18CE, {2'b00, ucp_ma});
    chk("adp", 16'h1964, {1'b0, adp_mv});
    chk("bus", 16'h1770, {2'b00, bus_mv});
    chk("pd", 16'h0001, {15'h0000, pd});
    host_u.pulse_reset();
    rchk(8'h04, 8'h28);
    rchk(8'h05, 8'h03);
    rchk(8'h06, 8'h3A);
    // pump running closes the FET and drops the pulldown
    pump = 1'b1;
    settle();
    chk("fet", 16'h0001, {15'h0000, fet});
    chk("pd", 16'h0000, {15'h0000, pd});
    aovp = 1'b1;
    settle();
    chk("fet", 16'h0000, {15'h0000, fet});
    chk("irq", 16'h0001, {15'h0000, irq});
    rchk(8'h05, 8'hC3);
    rchk(8'h05, 8'h83);
    chk("irq", 16'h0000, {15'h0000, irq});
    aovp = 1'b0;
    settle();
    host_u.write_reg(8'h05, 8'h23);
    aovp = 1'b1;
    settle();
    chk("irq", 16'h0000, {15'h0000, irq});
    rchk(8'h05, 8'hE3);
    aovp = 1'b0;
    settle();
    rchk(8'h05, 8'h23);
    // undercurrent alarm, then disabled
    uc = 1'b1;
    settle();
    chk("irq", 16'h0001, {15'h0000, irq});
    host_u.write_reg(8'h04, 8'hA8);
    settle();
    chk("irq", 16'h0000, {15'h0000, irq});
    uc = 1'b0;
    host_u.write_reg(8'h06, 8'hBA);
    settle();
    chk("pd", 16'h0001, {15'h0000, pd});
    chk("fet", 16'h0000, {15'h0000, fet});
    host_u.write_reg(8'h06, 8'h3A);
    // bus overvoltage: one clear pulse, switch opens
    pulses = 0;
    bovp = 1'b1;
    repeat (10) begin
      @(negedge clk);
      if (ce_clr === 1'b1) pulses++;
    end
    chk("clr", 16'h0001, pulses[15:0]);
    chk("sw", 16'h0000, {15'h0000, sw});
    bovp = 1'b0;
    settle();
    chk("sw", 16'h0001, {15'h0000, sw});
    // mid-run hardware reset drops a written code back to its default
    host_u.write_reg(8'h04, 8'h11);
    settle();
    chk("ucp", 16'h0352, {2'b00, ucp_ma});
    rst = 1'b1;
    @(negedge clk);
    chk("ucp", 16'h07D0, {2'b00, ucp_ma});
    chk("irq", 16'h0000, {15'h0000, irq});
    chk("pd", 16'h0001, {15'h0000, pd});
    rst = 1'b0;
    rchk(8'h04, 8'h28);
    conclude();
  end
endmodule
